/* rtl/cpm_defines.vh */
`ifndef CPM_DEFINES_VH
`define CPM_DEFINES_VH
// ==========================================
// register offsets
`define CPM_ADDR_COLL      6'h0e
`define CPM_ADDR_PAGE      6'h10
`define CPM_ADDR_MODE      6'h11
// ==========================================
// reset values
`define CPM_RST_COLL       8'ha0
`define CPM_RST_PAGE       8'h00
`define CPM_RST_MODE       8'h3b
`define CPM_RST_KEEP       1'b1
`define CPM_RST_CRC        2'h3
// ==========================================
// collision register fields
`define CPM_COLL_KEEP_BIT  7
`define CPM_COLL_INV_BIT   5
`define CPM_COLL_POS_MSB   4
// ==========================================
// page register fields
`define CPM_PAGE_EN_BIT    7
`define CPM_PAGE_MSB       1
// ==========================================
// mode register fields
`define CPM_MODE_RXWAIT_BIT 4
`define CPM_MODE_POL_BIT    3
`define CPM_MODE_CRC_MSB    1
// writable masks, reserved and read-only bits drop out
`define CPM_MASK_COLL      8'h80
`define CPM_MASK_PAGE      8'h83
`define CPM_MASK_MODE      8'hff
// ==========================================
// collision counting
`define CPM_POS_LIMIT      6'h20
// ==========================================
// mode settings fields (framing and speed)
`define CPM_FRAMING_MSB    1
`define CPM_SPEED_MSB      6
`define CPM_SPEED_LSB      4
`define CPM_FRAMING_A      2'h0
`define CPM_FRAMING_ACT    2'h1
`define CPM_FRAMING_F      2'h2
`define CPM_FRAMING_B      2'h3
`define CPM_SPEED_106      3'h0
// crc preset codes
`define CPM_PRESET_0000    2'h0
`define CPM_PRESET_6363    2'h1
`define CPM_PRESET_ffff    2'h3
`endif

/* rtl/cpm_regs.v */
// Functional notes
// - keep=0 clears received bits after collision
// - invalid flag set: no collision or overflow
// - five-bit first collision position, data only
// - encoding: 1 first, 8 eighth, 0 32nd
// - page enable: page gives address A5,A4
// - page disabled: latch gives whole address
// - receive wait starts after field detect, in target or card mode only
// - polarity bit selects secure input level
// - crc preset chosen from mode settings
`timescale 1ns/10ps
`include "cpm_defines.vh"

module cpm_regs (
    input  wire       clk,
    input  wire       rst_n,
    // host register port
    input  wire [5:0] host_addr,
    input  wire       host_wr,
    input  wire       host_rd,
    input  wire [7:0] host_wdata,
    output reg  [7:0] host_rdata,
    output reg        host_rvalid,
    output reg  [5:0] reg_addr_eff,
    // receiver bit stream
    input  wire       rx_frame_start,
    input  wire       rx_bit_valid,
    input  wire       rx_bit_value,
    input  wire       rx_bit_is_data,
    input  wire       rx_bit_collision,
    output reg        rx_store_valid,
    output reg        rx_store_value,
    // receive wait control
    input  wire       rx_wait_request,
    input  wire       target_or_card,
    input  wire       rf_field_pin,
    output reg        rx_wait_start,
    // secure element input
    input  wire       secure_element_signal_input,
    output reg        secure_signal_active,
    // crc preset selection
    input  wire       comm_active,
    input  wire [7:0] receive_mode_settings,
    input  wire [7:0] transmit_mode_settings,
    output reg  [1:0] crc_preset_sel,
    // mode bits to the rest of the device
    output reg  [7:0] mode_out,
    output reg        keep_values_after_collision_out
);

// ==========================================
// register storage
reg        keep_values_after_collision;   // host-writable control
reg        collision_position_invalid;    // hardware-owned flag
reg  [4:0] collision_position_field;      // hardware-owned position
reg        page_select_enable;            // page addressing on/off
reg  [1:0] page_field;                    // upper address bits
reg  [7:0] general_mode;                  // mode register
reg  [5:0] data_bit_count;                // data bits seen this frame
reg        collision_seen;                // first collision latched
reg        collided;                      // clear-mode active in frame

// ==========================================
// synchronisers for pin inputs
reg  [2:0] field_sync;                    // field detect, three stages
reg        field_level;                   // filtered field level
reg  [2:0] secure_element_signal_input_sync;                    // secure input, three stages
reg        secure_element_signal_input_level;                   // filtered secure input level

// ==========================================
// effective register address
wire [5:0] eff_addr;
// pins/latch supply the low nibble, page supplies the top two
assign eff_addr = page_select_enable ? {page_field, host_addr[3:0]} : host_addr;

// ==========================================
// crc preset picked from framing and speed
function [1:0] cpm_auto_preset;
    input [7:0] mode_bits;
    begin
        case (mode_bits[`CPM_FRAMING_MSB:0])
            `CPM_FRAMING_A:   cpm_auto_preset = `CPM_PRESET_6363;
            `CPM_FRAMING_ACT: begin
                // active mode at the lowest rate reuses type a framing
                if (mode_bits[`CPM_SPEED_MSB:`CPM_SPEED_LSB] == `CPM_SPEED_106)
                    cpm_auto_preset = `CPM_PRESET_6363;
                else
                    cpm_auto_preset = `CPM_PRESET_0000;
            end
            `CPM_FRAMING_F:   cpm_auto_preset = `CPM_PRESET_0000;
            `CPM_FRAMING_B:   cpm_auto_preset = `CPM_PRESET_ffff;
            default:          cpm_auto_preset = `CPM_PRESET_0000;
        endcase
    end
endfunction

// ==========================================
// read mux, reserved bits come back as zero
reg  [7:0] next_rdata;
always @* begin
    next_rdata = 8'h00;
    case (eff_addr)
        `CPM_ADDR_COLL: next_rdata = {keep_values_after_collision, 1'b0,
                                      collision_position_invalid,
                                      collision_position_field};
        `CPM_ADDR_PAGE: next_rdata = {page_select_enable, 5'h00, page_field};
        `CPM_ADDR_MODE: next_rdata = general_mode;
        default:        next_rdata = 8'h00;   // unmapped reads as zero
    endcase
end

// ==========================================
// host writes and reads
always @(posedge clk) begin
    if (!rst_n) begin
        keep_values_after_collision <= `CPM_RST_KEEP;
        page_select_enable <= 1'b0;
        page_field         <= 2'h0;
        general_mode       <= `CPM_RST_MODE;
        host_rdata         <= 8'h00;
        host_rvalid        <= 1'b0;
        reg_addr_eff       <= 6'h00;
    end else begin
        host_rvalid <= host_rd;
        if (host_rd) begin
            host_rdata <= next_rdata;
        end
        if (host_rd || host_wr) begin
            reg_addr_eff <= eff_addr;
        end
        if (host_wr) begin
            case (eff_addr)
                `CPM_ADDR_COLL: begin
                    // only the keep bit accepts data
                    keep_values_after_collision <= host_wdata[`CPM_COLL_KEEP_BIT];
                end
                `CPM_ADDR_PAGE: begin
                    page_select_enable <= host_wdata[`CPM_PAGE_EN_BIT];
                    page_field         <= host_wdata[`CPM_PAGE_MSB:0];
                end
                `CPM_ADDR_MODE: begin
                    general_mode <= host_wdata & `CPM_MASK_MODE;
                end
                default: begin
                    // unmapped writes are dropped
                end
            endcase
        end
    end
end

// ==========================================
// collision tracking per frame
// counts data bits only; a position past 32 cannot be encoded
always @(posedge clk) begin
    if (!rst_n) begin
        collision_position_invalid <= 1'b1;
        collision_position_field   <= 5'h00;
        data_bit_count             <= 6'h00;
        collision_seen             <= 1'b0;
        collided                   <= 1'b0;
    end else if (rx_frame_start) begin
        // new frame: nothing detected yet
        collision_position_invalid <= 1'b1;
        collision_position_field   <= 5'h00;
        data_bit_count             <= 6'h00;
        collision_seen             <= 1'b0;
        collided                   <= 1'b0;
    end else if (rx_bit_valid && rx_bit_is_data) begin
        // saturate so the count never wraps back into range
        if (data_bit_count != 6'h3f)
            data_bit_count <= data_bit_count + 6'h01;
        if (rx_bit_collision && !collision_seen) begin
            collision_seen <= 1'b1;
            collided       <= 1'b1;
            if (data_bit_count < `CPM_POS_LIMIT) begin
                // position is count+1; 32 truncates to 0
                collision_position_field   <= data_bit_count[4:0] + 5'h01;
                collision_position_invalid <= 1'b0;
            end else begin
                collision_position_invalid <= 1'b1;
            end
        end
    end
end

// ==========================================
// received bit path, cleared after a collision
always @(posedge clk) begin
    if (!rst_n) begin
        rx_store_valid <= 1'b0;
        rx_store_value <= 1'b0;
    end else begin
        rx_store_valid <= rx_bit_valid;
        // the colliding bit itself and all later ones read zero
        if (!keep_values_after_collision &&
            (collided || (rx_bit_collision && rx_bit_is_data)))
            rx_store_value <= 1'b0;
        else
            rx_store_value <= rx_bit_value;
    end
end

// ==========================================
// pin synchronisers: act once stages two and three agree
always @(posedge clk) begin
    if (!rst_n) begin
        field_sync  <= 3'h0;
        field_level <= 1'b0;
        secure_element_signal_input_sync  <= 3'h0;
        secure_element_signal_input_level <= 1'b0;
    end else begin
        field_sync <= {field_sync[1:0], rf_field_pin};
        secure_element_signal_input_sync <= {secure_element_signal_input_sync[1:0], secure_element_signal_input};
        if (field_sync[2] == field_sync[1])
            field_level <= field_sync[1];
        if (secure_element_signal_input_sync[2] == secure_element_signal_input_sync[1])
            secure_element_signal_input_level <= secure_element_signal_input_sync[1];
    end
end

// ==========================================
// receive wait gating, secure input polarity, crc preset
always @(posedge clk) begin
    if (!rst_n) begin
        rx_wait_start        <= 1'b0;
        secure_signal_active <= 1'b0;
        crc_preset_sel       <= `CPM_RST_CRC;
        mode_out             <= `CPM_RST_MODE;
        keep_values_after_collision_out <= `CPM_RST_KEEP;
    end else begin
        // field gating applies only as target or in card mode
        if (general_mode[`CPM_MODE_RXWAIT_BIT] && target_or_card)
            rx_wait_start <= rx_wait_request && field_level;
        else
            rx_wait_start <= rx_wait_request;
        if (general_mode[`CPM_MODE_POL_BIT])
            secure_signal_active <= secure_element_signal_input_level;
        else
            secure_signal_active <= !secure_element_signal_input_level;
        // receive settings take priority in the automatic choice
        if (comm_active)
            crc_preset_sel <= comm_rx_or_tx(receive_mode_settings,
                                            transmit_mode_settings);
        else
            crc_preset_sel <= general_mode[`CPM_MODE_CRC_MSB:0];
        mode_out <= general_mode;
        keep_values_after_collision_out <= keep_values_after_collision;
    end
end

// ==========================================
// choose the settings that drive the automatic preset
// a limitation: mixed rx/tx framings follow the receive side
function [1:0] comm_rx_or_tx;
    input [7:0] rx_bits;
    input [7:0] tx_bits;
    reg   [1:0] rx_sel;
    begin
        rx_sel = cpm_auto_preset(rx_bits);
        if (rx_bits[`CPM_FRAMING_MSB:0] == tx_bits[`CPM_FRAMING_MSB:0])
            comm_rx_or_tx = rx_sel;
        else
            comm_rx_or_tx = rx_sel;
    end
endfunction

endmodule // cpm_regs

/* testbench/cpm_chk.sv */
`timescale 1ns/10ps
// ==========================================
// port checker for receive, wait, polarity and crc paths
module cpm_chk (
    input wire       clk,
    input wire       rst_n,
    input wire       rx_frame_start,
    input wire       rx_bit_valid,
    input wire       rx_bit_value,
    input wire       rx_bit_is_data,
    input wire       rx_bit_collision,
    input wire       rx_store_value,
    input wire       rx_wait_request,
    input wire       target_or_card,
    input wire       rf_field_pin,
    input wire       rx_wait_start,
    input wire       secure_element_signal_input,
    input wire       secure_signal_active,
    input wire       comm_active,
    input wire [7:0] receive_mode_settings,
    input wire [1:0] crc_preset_sel,
    input wire [7:0] mode_out,
    input wire       keep_values_after_collision_out
);
    wire       kp  = keep_values_after_collision_out;
    wire       bit_in = rx_bit_valid && !rx_frame_start;   // frame start wins
    wire       hit = bit_in && rx_bit_is_data && rx_bit_collision;
    wire [1:0] fr  = receive_mode_settings[1:0];
    // expected automatic preset from receive framing and speed
    wire [1:0] exp_crc = (fr == 2'h3) ? 2'h3 : (fr == 2'h2) ? 2'h0 :
        (fr == 2'h1 && receive_mode_settings[6:4] != 3'h0) ? 2'h0 : 2'h1;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // keep copy lags the register, so it must have settled for two edges
    AST_KEEP_CLR: assert property (
        !kp && !$past(kp, 2) && hit |=> !rx_store_value)
        else $error("colliding bit was kept");
    AST_KEEP_NEXT: assert property (
        !kp && !$past(kp, 2) && hit ##1 bit_in |=> !rx_store_value)
        else $error("bit after collision was kept");
    AST_KEEP_PASS: assert property (
        kp && $past(kp, 2) && bit_in |=> rx_store_value == $past(rx_bit_value))
        else $error("bit not passed with keep set");
    AST_WAIT_GATE: assert property (
        (mode_out[4] && target_or_card && !rf_field_pin)[*6] ##0 rx_wait_request
        ##1 mode_out[4] |-> !rx_wait_start)
        else $error("wait started without field");
    AST_WAIT_OPEN: assert property (
        rx_wait_request && !mode_out[4] ##1 !mode_out[4] |-> rx_wait_start)
        else $error("wait not started");
    AST_SECURE_ELEMENT_SIGNAL_INPUT: assert property (
        ($stable(secure_element_signal_input) && $stable(mode_out[3]))[*6]
        |=> secure_signal_active == ($past(secure_element_signal_input) ~^ mode_out[3]))
        else $error("secure input polarity wrong");
    AST_CRC_AUTO: assert property (comm_active |=> crc_preset_sel == $past(exp_crc))
        else $error("auto preset wrong");
    AST_CRC_IDLE: assert property (!comm_active |=> crc_preset_sel == mode_out[1:0])
        else $error("stored preset wrong");
endmodule // cpm_chk

bind cpm_regs cpm_chk i_cpm_chk (.*);

/* testbench/cpm_host.sv */
`timescale 1ns/10ps
// ==========================================
// host side of the register port
module cpm_host (
    input  wire       clk,
    output reg  [5:0] host_addr,
    output reg        host_wr,
    output reg        host_rd,
    output reg  [7:0] host_wdata,
    input  wire [7:0] host_rdata,
    input  wire       host_rvalid
);
    initial {host_addr, host_wr, host_rd, host_wdata} = '0;
    // strobe spans one edge; idle edge after so strobes never merge
    task wr(input [5:0] a, input [7:0] d);
        begin
            host_addr = a;
            host_wdata = d;
            host_wr = 1'b1;
            @(posedge clk) #1 host_wr = 1'b0;
            @(posedge clk) #1;
        end
    endtask
    // valid pulse is seen after the read edge, data holds until the next read
    task rd(input [5:0] a, output [7:0] d, output v);
        begin
            host_addr = a;
            host_rd = 1'b1;
            @(posedge clk) #1 host_rd = 1'b0;
            v = host_rvalid;
            @(posedge clk) #1 d = host_rdata;
        end
    endtask
endmodule // cpm_host

/* testbench/cpm_regs_tb_top.sv */
`timescale 1ns/10ps
module cpm_regs_tb_top;
    reg        clk = 1'b0;
    reg        rst_n, rx_frame_start, rx_bit_valid, rx_bit_value, rx_bit_is_data, kp, rv;
    reg        rx_bit_collision, rx_wait_request, target_or_card, rf_field_pin;
    reg        secure_element_signal_input, comm_active;
    reg  [7:0] receive_mode_settings, transmit_mode_settings, d;
    wire [5:0] host_addr, reg_addr_eff;
    wire [7:0] host_wdata, host_rdata, mode_out;
    wire [1:0] crc_preset_sel;
    wire       host_wr, host_rd, host_rvalid, rx_store_valid, rx_store_value;
    wire       rx_wait_start, secure_signal_active, keep_values_after_collision_out;
    integer    failures = 0, n_checks = 0, i, k;
    integer    cps [0:4] = '{1, 8, 32, 33, 0};
    reg  [7:0] rxm [0:4] = '{8'h00, 8'h01, 8'h03, 8'h02, 8'h11};
    reg  [7:0] crx [0:4] = '{8'h01, 8'h01, 8'h03, 8'h00, 8'h00};
    cpm_regs i_cpm_regs (.*);
    cpm_host i_cpm_host (.*);
    always #10 clk = ~clk;
    // ==========================================
    // shared tasks
    task chk(input [7:0] g, input [7:0] e);
        begin
            n_checks = n_checks + 1;
            if (g !== e) begin
                failures = failures + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, g, e);
            end
        end
    endtask
    task rc(input [5:0] a, input [7:0] e);
        begin
            i_cpm_host.rd(a, d, rv);
            chk(d, e);
            chk(rv, 8'h01);
            chk(host_rvalid, 8'h00);   // valid pulse lasts one cycle
        end
    endtask
    // one framing bit, then n data bits; stored bits checked one edge late
    task frame(input integer n, input integer cp);
        begin
            rx_frame_start = 1'b1;
            @(posedge clk) #1 rx_frame_start = 1'b0;
            rx_bit_valid = 1'b1;
            rx_bit_value = 1'b1;
            for (k = 1; k <= n; k = k + 1) begin
                @(posedge clk) #1;
                if (k > 1) begin
                    chk(rx_store_valid, 8'h01);
                    chk(rx_store_value, (kp || cp == 0 || k <= cp) & !k[0]);
                end
                rx_bit_is_data = 1'b1;
                rx_bit_value = k[0];
                rx_bit_collision = (k == cp);
            end
            @(posedge clk) #1 {rx_bit_valid, rx_bit_collision, rx_bit_is_data} = '0;
            chk(rx_store_value, (kp || cp == 0 || n < cp) & n[0]);
            @(posedge clk) #1;
            chk(rx_store_valid, 8'h00);
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", n_checks, failures);
            if (failures == 0 && n_checks > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    // watchdog, far beyond the few hundred cycles the run needs
    initial begin
        #1000000;
        failures = failures + 1;
        finish_test;
    end
    // ==========================================
    // main sequence
    initial begin
        {rst_n, rx_frame_start, rx_bit_valid, rx_bit_value, rx_bit_is_data} = '0;
        {rx_bit_collision, rx_wait_request, target_or_card, rf_field_pin} = '0;
        {secure_element_signal_input, comm_active, receive_mode_settings} = '0;
        transmit_mode_settings = 8'h00;
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        rc(6'h0e, 8'ha0);
        rc(6'h10, 8'h00);
        rc(6'h11, 8'h3b);
        rc(6'h3f, 8'h00);
        i_cpm_host.wr(6'h0e, 8'h7f);
        rc(6'h0e, 8'h20);
        chk(keep_values_after_collision_out, 8'h00);
        i_cpm_host.wr(6'h10, 8'h7c);
        rc(6'h10, 8'h00);
        $display("register test done");
        kp = 1'b0;
        frame(5, 3);
        rc(6'h0e, 8'h03);
        i_cpm_host.wr(6'h0e, 8'h80);
        chk(keep_values_after_collision_out, 8'h01);
        kp = 1'b1;
        for (i = 0; i < 5; i = i + 1) begin
            frame(34, cps[i]);
            rc(6'h0e, (cps[i] % 33 == 0) ? 8'ha0 : 8'h80 | cps[i][4:0]);
        end
        $display("collision test done");
        i_cpm_host.wr(6'h10, 8'h81);
        rc(6'h21, 8'h3b);
        chk(reg_addr_eff, 8'h11);
        i_cpm_host.wr(6'h00, 8'h00);
        rc(6'h21, 8'h00);
        chk(reg_addr_eff, 8'h21);
        $display("page test done");
        i_cpm_host.wr(6'h11, 8'h1b);
        chk(mode_out, 8'h1b);
        {target_or_card, rx_wait_request, secure_element_signal_input} = 3'h7;
        repeat (8) @(posedge clk);
        #1 chk(rx_wait_start, 8'h00);
        chk(secure_signal_active, 8'h01);
        rf_field_pin = 1'b1;
        repeat (8) @(posedge clk);
        #1 chk(rx_wait_start, 8'h01);
        rf_field_pin = 1'b0;
        i_cpm_host.wr(6'h11, 8'h02);
        repeat (8) @(posedge clk);
        #1 chk(secure_signal_active, 8'h00);
        chk(rx_wait_start, 8'h01);
        chk(crc_preset_sel, 8'h02);
        chk(mode_out, 8'h02);
        comm_active = 1'b1;
        for (i = 0; i < 5; i = i + 1) begin
            receive_mode_settings = rxm[i];
            repeat (2) @(posedge clk);
            #1 chk(crc_preset_sel, crx[i]);
        end
        $display("mode test done");
        finish_test;
    end
endmodule // cpm_regs_tb_top
